// File: pkg/fdds_pkg.sv
// Shared constants and carrier types of the four-channel synthesizer core
//
// Contract
// - Update rising edge copies buffer into active registers
// - Sync clock is system clock over four, switchable
// - Update and profiles sampled at sync clock rise
// - Serial writes on rising, reads on falling
// - Serial port responds only while select low
// - Lane zero is serial data only
// - Lanes one, two: data or ramp triggers; the core uses them as ramp triggers only
// - Lane three is sync input in narrow modes
// - Four channels, 32-bit accumulator plus converter
// - Accumulator adds tuning word each clock, wraps
// - Phase converted to cosine amplitude
// - Each channel holds 14-bit phase offset
// - Offset added to phase before conversion
// - Separate phase offset storage per channel
// - All accumulators share one system clock
// - Each channel delivers own 10-bit code
// - Reset forces every register to default
// - Profile pin function set by config bits
// - Channel enables act at once, no update
package fdds_pkg;

  localparam int NUM_CH = 4;
  localparam int ACC_W  = 32;
  localparam int POW_W  = 14;
  localparam int DAC_W  = 10;

  // --------------------------------------------------------------------------
  // Register indices, byte address is four times the index
  // --------------------------------------------------------------------------
  localparam logic [4:0] IDX_CSR    = 5'h00;
  localparam logic [4:0] IDX_FR1    = 5'h01;
  localparam logic [4:0] IDX_FTW    = 5'h04;
  localparam logic [4:0] IDX_CHANNEL_PHASE_OFFSET   = 5'h05;
  localparam logic [4:0] IDX_STATUS = 5'h06;

  // Serial transfer length of each register except status, in bytes
  localparam logic [2:0] LEN_CSR  = 3'h1;
  localparam logic [2:0] LEN_FR1  = 3'h3;
  localparam logic [2:0] LEN_FTW  = 3'h4;
  localparam logic [2:0] LEN_CHANNEL_PHASE_OFFSET = 3'h2;

  // --------------------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------------------
  localparam int CSR_EN_LSB    = 4;
  localparam int CSR_MODE_LSB  = 1;
  localparam int FR1_PPC_LSB   = 12;
  localparam int FR1_SYNC_OFF  = 5;
  localparam int FR1_RAMP_LANE = 4;
  localparam int INSTR_RD_BIT  = 7;

  // --------------------------------------------------------------------------
  // Reset values and encodings
  // --------------------------------------------------------------------------
  localparam logic [7:0]  CSR_RST  = 8'hF0;
  localparam logic [23:0] FR1_RST  = 24'h00_0000;
  localparam logic [31:0] FTW_RST  = 32'h0000_0000;
  localparam logic [13:0] POW_RST  = 14'h0000;
  localparam logic [1:0]  MODE_2BIT = 2'h1;
  localparam logic [2:0]  PPC_RAMP = 3'h1;
  localparam logic [2:0]  PPC_PSK  = 3'h2;
  localparam logic [9:0]  AMP_FULL = 10'h3FF;
  localparam logic [13:0] PHASE_QTR  = 14'h1000;
  localparam logic [13:0] PHASE_HALF = 14'h2000;

  // --------------------------------------------------------------------------
  // Timing: sync clock divide, rise seen when the divider leaves this count
  // --------------------------------------------------------------------------
  localparam int         SYNC_DIV   = 4;
  localparam logic [1:0] SYNC_RISE  = 2'h1;
  localparam logic [1:0] SYNC_HIGH2 = 2'h2;

  typedef struct packed {
    logic [ACC_W-1:0] frequency_tuning_word;
    logic [POW_W-1:0] phase_offset_value;
  } fdds_chan_cfg_t;

endpackage

// File: core/fdds_channel.sv
// One synthesis channel: accumulator, phase offset, cosine converter, scaling
`timescale 1ns/100ps
`default_nettype none
module fdds_channel
(
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 ce_i,
  // Active settings
  input  wire fdds_pkg::fdds_chan_cfg_t cfg_i,
  input  wire logic [9:0]           amp_i,
  input  wire logic                 psk_i,
  // Converter word, offset binary
  output logic [9:0]                dac_o
);

  logic [31:0] acc;
  logic [13:0] phase;
  logic        neg;
  logic [8:0]  mag;
  logic [9:0]  amp_d;
  logic [12:0] x;
  logic [25:0] prod;
  logic [18:0] scaled;

  // --------------------------------------------------------------------------
  // Accumulator and offset; fixed four-stage pipe to the converter word
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      acc <= fdds_pkg::FTW_RST;
    else if (ce_i)
      acc <= acc + cfg_i.frequency_tuning_word;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      phase <= fdds_pkg::POW_RST;
    else if (ce_i)
      // Quarter turn turns the sine shape into cosine
      phase <= acc[31:18] + cfg_i.phase_offset_value + fdds_pkg::PHASE_QTR
               + (psk_i ? fdds_pkg::PHASE_HALF : 14'h0000);
  end

  // Parabolic half-wave x*(1-x): cheap, within a few percent of a true sine
  assign x    = phase[12:0];
  assign prod = 26'(x) * 26'(14'h2000 - {1'b0, x});

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mag   <= 9'h000;
      neg   <= 1'b0;
      amp_d <= 10'h000;
    end
    else if (ce_i)
    begin
      mag   <= (prod[25:15] > 11'h1FF) ? 9'h1FF : prod[23:15];
      neg   <= phase[13];
      amp_d <= amp_i;
    end
  end

  assign scaled = 19'(mag) * 19'(amp_d);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dac_o <= 10'h200;
    else if (ce_i)
      dac_o <= neg ? 10'(10'h200 - {1'b0, scaled[18:10]})
                   : 10'(10'h200 + {1'b0, scaled[18:10]});
  end

endmodule
`default_nettype wire

// File: core/fdds_core.sv
// Four-channel synthesizer core: serial port, register bus, update, channels
//
// Local design decisions: the Wishbone register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module fdds_core
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Update strobe and profile inputs, sync clock output
  input  wire logic        io_update_i,
  input  wire logic [3:0]  profile_inputs_i,
  output logic             sync_clk_o,
  // Serial port
  input  wire logic        cs_n_i,
  input  wire logic        sclk_i,
  input  wire logic        sdio0_i,
  output logic             sdio0_o,
  output logic             sdio0_oe_o,
  input  wire logic        sdio1_i,
  input  wire logic        sdio2_i,
  input  wire logic        sdio3_i,
  // Converter words
  output logic [39:0]      dac_o
);

  typedef enum {SP_INSTR, SP_DATA, SP_DONE} fdds_sp_state_t;

  // --------------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------------
  function automatic logic [2:0] reg_len(input logic [4:0] idx);
    case (idx)
      fdds_pkg::IDX_CSR:  reg_len = fdds_pkg::LEN_CSR;
      fdds_pkg::IDX_FR1:  reg_len = fdds_pkg::LEN_FR1;
      fdds_pkg::IDX_FTW:  reg_len = fdds_pkg::LEN_FTW;
      fdds_pkg::IDX_CHANNEL_PHASE_OFFSET: reg_len = fdds_pkg::LEN_CHANNEL_PHASE_OFFSET;
      default:            reg_len = 3'h0;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  function automatic logic [31:0] align_msb(input logic [31:0] w, input logic [2:0] len);
    case (len)
      3'h1:    align_msb = {w[7:0], 24'h00_0000};
      3'h2:    align_msb = {w[15:0], 16'h0000};
      3'h3:    align_msb = {w[23:0], 8'h00};
      default: align_msb = w;
    endcase
  endfunction

  // --------------------------------------------------------------------------
  // Pin synchronisers: two flops before any logic looks at a pin
  // --------------------------------------------------------------------------
  logic [9:0] pins_m;
  logic [9:0] pins_s;
  logic       sclk_d;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pins_m <= 10'h002;
      pins_s <= 10'h002;
      sclk_d <= 1'b0;
    end
    else if (ce_i)
    begin
      pins_m <= {profile_inputs_i, io_update_i, sdio3_i, sdio2_i, sdio1_i, cs_n_i, sclk_i};
      pins_s <= pins_m;
      sclk_d <= pins_s[0];
    end
  end

  logic       sclk_s;
  logic       cs_n_s;
  logic       lane1_s;
  logic       lane2_s;
  logic       lane3_s;
  logic       upd_s;
  logic [3:0] prof_s;
  logic       sdio0_m;
  logic       sdio0_s;

  assign sclk_s  = pins_s[0];
  assign cs_n_s  = pins_s[1];
  assign lane1_s = pins_s[2];
  assign lane2_s = pins_s[3];
  assign lane3_s = pins_s[4];
  assign upd_s   = pins_s[5];
  assign prof_s  = pins_s[9:6];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sdio0_m <= 1'b0;
      sdio0_s <= 1'b0;
    end
    else if (ce_i)
    begin
      sdio0_m <= sdio0_i;
      sdio0_s <= sdio0_m;
    end
  end

  // --------------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------------
  logic [7:0]               channel_select_register;
  logic [23:0]              fr1_buf;
  logic [23:0]              fr1_act;
  fdds_pkg::fdds_chan_cfg_t buf_cfg [4];
  fdds_pkg::fdds_chan_cfg_t act_cfg [4];
  logic [7:0]               upd_cnt;
  logic [3:0]               prof_smp;
  logic [3:0]               ch_en;
  logic [1:0]               ser_mode;
  logic [1:0]               first_en;

  assign ch_en    = channel_select_register[fdds_pkg::CSR_EN_LSB +: 4];
  assign ser_mode = channel_select_register[fdds_pkg::CSR_MODE_LSB +: 2];
  assign first_en = ch_en[0] ? 2'h0 : ch_en[1] ? 2'h1 : ch_en[2] ? 2'h2 : ch_en[3] ? 2'h3 : 2'h0;

  // Reads of shared channel registers show the lowest enabled channel
  function automatic logic [31:0] rd_word(input logic [4:0] idx);
    case (idx)
      fdds_pkg::IDX_CSR:    rd_word = {24'h00_0000, channel_select_register};
      fdds_pkg::IDX_FR1:    rd_word = {8'h00, fr1_buf};
      fdds_pkg::IDX_FTW:    rd_word = buf_cfg[first_en].frequency_tuning_word;
      fdds_pkg::IDX_CHANNEL_PHASE_OFFSET:   rd_word = {18'h0_0000, buf_cfg[first_en].phase_offset_value};
      fdds_pkg::IDX_STATUS: rd_word = {20'h0_0000, prof_smp, upd_cnt};
      default:              rd_word = 32'h0000_0000;
    endcase
  endfunction

  // --------------------------------------------------------------------------
  // Serial port
  // --------------------------------------------------------------------------
  fdds_sp_state_t sp_state;
  logic [5:0]     bit_cnt;
  logic [31:0]    shreg;
  logic [31:0]    tx;
  logic [4:0]     sp_idx;
  logic [2:0]     sp_len;
  logic           sp_rd;
  logic           ser_wr;
  logic [31:0]    ser_data;
  logic           sclk_rise;
  logic           sclk_fall;
  logic           sp_abort;
  logic [4:0]     instr_idx;
  logic [2:0]     instr_len;

  assign sclk_rise = sclk_s & ~sclk_d;
  assign sclk_fall = ~sclk_s & sclk_d;
  assign sp_abort  = cs_n_s | ((ser_mode <= fdds_pkg::MODE_2BIT) & lane3_s);
  assign instr_idx = {shreg[3:0], sdio0_s};
  assign instr_len = reg_len(instr_idx);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sp_state   <= SP_INSTR;
      bit_cnt    <= 6'h00;
      shreg      <= 32'h0000_0000;
      tx         <= 32'h0000_0000;
      sp_idx     <= 5'h00;
      sp_len     <= 3'h0;
      sp_rd      <= 1'b0;
      ser_wr     <= 1'b0;
      ser_data   <= 32'h0000_0000;
      sdio0_o    <= 1'b0;
      sdio0_oe_o <= 1'b0;
    end
    else if (ce_i)
    begin
      ser_wr <= 1'b0;
      if (sp_abort)
      begin
        sp_state   <= SP_INSTR;
        bit_cnt    <= 6'h00;
        sdio0_oe_o <= 1'b0;
      end
      else
      begin
        if (sclk_rise)
        begin
          shreg <= {shreg[30:0], sdio0_s};
          case (sp_state)
            SP_INSTR:
            begin
              bit_cnt <= bit_cnt + 6'h01;
              if (bit_cnt == 6'h07)
              begin
                bit_cnt  <= 6'h00;
                sp_idx   <= instr_idx;
                sp_len   <= instr_len;
                sp_rd    <= shreg[fdds_pkg::INSTR_RD_BIT-1];
                tx       <= align_msb(rd_word(instr_idx), instr_len);
                sp_state <= (instr_len == 3'h0) ? SP_DONE : SP_DATA;
              end
            end
            SP_DATA:
            begin
              bit_cnt <= bit_cnt + 6'h01;
              if (bit_cnt == {sp_len, 3'h7} - 6'h08)
              begin
                sp_state <= SP_DONE;
                ser_wr   <= ~sp_rd;
                ser_data <= {shreg[30:0], sdio0_s};
              end
            end
            SP_DONE:  sp_state <= SP_DONE;
            default:  sp_state <= SP_INSTR;
          endcase
        end
        if (sclk_fall)
        begin
          if (sp_state == SP_DATA && sp_rd)
          begin
            sdio0_o    <= tx[31];
            tx         <= {tx[30:0], 1'b0};
            sdio0_oe_o <= 1'b1;
          end
          else
            sdio0_oe_o <= 1'b0;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Wishbone slave: one wait state; a serial write in the same cycle goes first
  // --------------------------------------------------------------------------
  logic [4:0]  wb_idx;
  logic        wb_take;
  logic        wr_en;
  logic [4:0]  wr_idx;
  logic [31:0] wr_data;
  logic [31:0] wr_mask;

  assign wb_idx  = wb_adr_i[6:2];
  assign wb_take = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~ser_wr;
  assign wr_en   = ser_wr | (wb_take & wb_we_i & ~wb_adr_i[7]);
  assign wr_idx  = ser_wr ? sp_idx : wb_idx;
  assign wr_data = ser_wr ? ser_data : wb_dat_i;
  assign wr_mask = ser_wr ? 32'hFFFF_FFFF
                 : {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      wb_ack_o <= wb_take;
      if (wb_take && !wb_we_i)
        wb_dat_o <= wb_adr_i[7] ? 32'h0000_0000 : rd_word(wb_idx);
    end
  end

  // --------------------------------------------------------------------------
  // Buffered registers; the select register acts at once
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      channel_select_register     <= fdds_pkg::CSR_RST;
      fr1_buf <= fdds_pkg::FR1_RST;
      for (int c = 0; c < fdds_pkg::NUM_CH; c++)
        buf_cfg[c] <= '{frequency_tuning_word: fdds_pkg::FTW_RST, phase_offset_value: fdds_pkg::POW_RST};
    end
    else if (ce_i && wr_en)
    begin
      case (wr_idx)
        fdds_pkg::IDX_CSR: channel_select_register <= 8'(merge({24'h00_0000, channel_select_register}, wr_data, wr_mask));
        fdds_pkg::IDX_FR1: fr1_buf <= 24'(merge({8'h00, fr1_buf}, wr_data, wr_mask));
        fdds_pkg::IDX_FTW:
          for (int c = 0; c < fdds_pkg::NUM_CH; c++)
            if (ch_en[c])
              buf_cfg[c].frequency_tuning_word <= merge(buf_cfg[c].frequency_tuning_word, wr_data, wr_mask);
        fdds_pkg::IDX_CHANNEL_PHASE_OFFSET:
          for (int c = 0; c < fdds_pkg::NUM_CH; c++)
            if (ch_en[c])
              buf_cfg[c].phase_offset_value <= 14'(merge({18'h0_0000, buf_cfg[c].phase_offset_value}, wr_data, wr_mask));
        default: channel_select_register <= channel_select_register;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Sync clock and pin sampling at its rising edge
  // --------------------------------------------------------------------------
  logic [1:0] div_cnt;
  logic       sync_tick;
  logic       upd_smp;
  logic       upd_edge;

  assign sync_tick = (div_cnt == fdds_pkg::SYNC_RISE);
  assign upd_edge  = sync_tick & upd_s & ~upd_smp;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      div_cnt    <= 2'h0;
      sync_clk_o <= 1'b0;
    end
    else if (ce_i)
    begin
      div_cnt    <= div_cnt + 2'h1;
      sync_clk_o <= ~fr1_act[fdds_pkg::FR1_SYNC_OFF]
                    & (sync_tick | (div_cnt == fdds_pkg::SYNC_HIGH2));
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      upd_smp  <= 1'b0;
      prof_smp <= 4'h0;
    end
    else if (ce_i && sync_tick)
    begin
      upd_smp  <= upd_s;
      prof_smp <= prof_s;
    end
  end

  // Active registers change only on a sampled update edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      fr1_act <= fdds_pkg::FR1_RST;
      upd_cnt <= 8'h00;
      for (int c = 0; c < fdds_pkg::NUM_CH; c++)
        act_cfg[c] <= '{frequency_tuning_word: fdds_pkg::FTW_RST, phase_offset_value: fdds_pkg::POW_RST};
    end
    else if (ce_i && upd_edge)
    begin
      fr1_act <= fr1_buf;
      upd_cnt <= upd_cnt + 8'h01;
      for (int c = 0; c < fdds_pkg::NUM_CH; c++)
        act_cfg[c] <= buf_cfg[c];
    end
  end

  // --------------------------------------------------------------------------
  // Profile pin function and amplitude ramps, one step per sync period
  // --------------------------------------------------------------------------
  logic [2:0] profile_pin_config;
  logic       lane_ramp;
  logic [9:0] amp [4];
  logic [3:0] ramp_en;
  logic [3:0] ramp_up;
  logic [3:0] psk;

  assign profile_pin_config       = fr1_act[fdds_pkg::FR1_PPC_LSB +: 3];
  assign lane_ramp = fr1_act[fdds_pkg::FR1_RAMP_LANE];

  always_comb
  begin
    for (int c = 0; c < fdds_pkg::NUM_CH; c++)
    begin
      ramp_en[c] = lane_ramp | (profile_pin_config == fdds_pkg::PPC_RAMP);
      ramp_up[c] = (lane_ramp & ((c < 2) ? lane1_s : lane2_s))
                 | ((profile_pin_config == fdds_pkg::PPC_RAMP) & prof_smp[c]);
      psk[c]     = (profile_pin_config == fdds_pkg::PPC_PSK) & prof_smp[c];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int c = 0; c < fdds_pkg::NUM_CH; c++)
        amp[c] <= fdds_pkg::AMP_FULL;
    end
    else if (ce_i && sync_tick)
    begin
      for (int c = 0; c < fdds_pkg::NUM_CH; c++)
        if (!ramp_en[c])
          amp[c] <= fdds_pkg::AMP_FULL;
        else if (ramp_up[c] && amp[c] != fdds_pkg::AMP_FULL)
          amp[c] <= amp[c] + 10'h001;
        else if (!ramp_up[c] && amp[c] != 10'h000)
          amp[c] <= amp[c] - 10'h001;
    end
  end

  // --------------------------------------------------------------------------
  // Channels: identical pipes on one clock keep latency matched
  // --------------------------------------------------------------------------
  for (genvar g = 0; g < fdds_pkg::NUM_CH; g++)
  begin : g_ch
    fdds_channel u_ch
    (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .ce_i  (ce_i),
      .cfg_i (act_cfg[g]),
      .amp_i (amp[g]),
      .psk_i (psk[g]),
      .dac_o (dac_o[g*10 +: 10])
    );
  end

endmodule
`default_nettype wire

// File: sim/fdds_core_sva.sv
// Port checker for the synthesizer core
`timescale 1ns/100ps
`default_nettype none
module fdds_core_sva
(
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Watched ports
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        sync_clk_o,
  input wire logic        cs_n_i,
  input wire logic        sclk_i,
  input wire logic        sdio0_o,
  input wire logic        sdio0_oe_o,
  input wire logic [39:0] dac_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack_gone;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  property p_rst;
    disable iff (1'b0)
    rst_i |=> dac_o == {4{10'h200}} && !wb_ack_o && !sync_clk_o && !sdio0_oe_o;
  endproperty
  property p_ack_bound;
    s_req |-> ##[1:3] wb_ack_o;
  endproperty
  property p_ack_pulse;
    wb_ack_o |-> s_ack_gone;
  endproperty
  property p_ack_cause;
    wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i);
  endproperty
  property p_sync_rise;
    $rose(sync_clk_o) |-> !$past(sync_clk_o, 2);
  endproperty
  property p_sync_low;
    $fell(sync_clk_o) |=> !sync_clk_o;
  endproperty
  // Select is synchronised first, so a few cycles of drive may remain
  property p_cs_oe;
    cs_n_i [*5] |-> !sdio0_oe_o;
  endproperty
  property p_sdo_fall;
    sclk_i [*5] |-> $stable(sdio0_o);
  endproperty

  a_rst: assert property (p_rst) else $error("reset state wrong");
  a_ack_bound: assert property (p_ack_bound) else $error("bus answer late");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  a_sync_rise: assert property (p_sync_rise) else $error("sync low phase short");
  a_sync_low: assert property (p_sync_low) else $error("sync low phase short");
  a_cs_oe: assert property (p_cs_oe) else $error("drives while deselected");
  a_sdo_fall: assert property (p_sdo_fall) else $error("read data moved on rise");
endmodule
`default_nettype wire

// File: sim/fdds_host.sv
// Host controller model: serial frames and update strobe
`timescale 1ns/100ps
`default_nettype none
module fdds_host
#(
  parameter int HP = 6
)
(
  // Clock
  input  wire logic clk_i,
  // Serial port and update
  output logic      cs_n_o,
  output logic      sclk_o,
  output logic      sdo_o,
  input  wire logic sdi_i,
  output logic      update_o
);
  initial
  begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    sdo_o = 1'b0;
    update_o = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Slow serial clock leaves the core's synchronisers margin
  task automatic xfer(input logic [7:0] ins, input logic [31:0] d, input int nb,
                      input logic sel, output logic [31:0] rd);
    logic [39:0] sh;
    sh = {ins, d << (8 * (4 - nb))};
    rd = 32'h0000_0000;
    cs_n_o <= ~sel;
    tick(HP);
    for (int i = 0; i < 8 + 8 * nb; i++)
    begin
      sdo_o <= (ins[7] && i > 7) ? ~sdo_o : sh[39 - i];
      tick(HP);
      sclk_o <= 1'b1;
      if (i > 7)
        rd = {rd[30:0], sdi_i};
      tick(HP);
      sclk_o <= 1'b0;
    end
    tick(HP);
    sdo_o <= ~sdo_o;
    cs_n_o <= 1'b1;
    tick(HP);
  endtask

  task automatic pulse_update();
    update_o <= 1'b1;
    tick(4 * HP);
    update_o <= 1'b0;
    tick(4 * HP);
  endtask
endmodule
`default_nettype wire

// File: sim/fdds_core_tb.sv
// Self-checking bench for the synthesizer core
`timescale 1ns/100ps
`default_nettype none
module fdds_core_tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc = 1'b0;
  logic        wb_stb = 1'b0;
  logic        wb_we = 1'b0;
  logic [7:0]  wb_adr = 8'h00;
  logic [31:0] wb_wdat = 32'h0000_0000;
  logic [31:0] wb_rdat;
  logic        wb_ack;
  logic        sync_clk;
  logic        sdo;
  logic        sdo_oe;
  logic        host_sdo;
  logic        cs_n;
  logic        sclk;
  logic        upd_pin;
  logic        sdio3 = 1'b0;
  logic        sdio1 = 1'b0;
  logic [3:0]  prof = 4'h0;
  logic [39:0] dac_o;
  wire         sdio0 = sdo_oe ? sdo : host_sdo;
  int          error_cnt = 0;
  int          checks_done = 0;
  int          cyc_cnt = 0;
  int          upd_cnt = 0;
  int          n;
  logic [31:0] q;
  logic [9:0]  v0;
  logic [9:0]  s [5];
  logic [7:0]  ra [5] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h80};
  logic [31:0] rv [5] = '{32'h0000_00F0, 32'h0, 32'h0, 32'h0, 32'h0};

  initial forever #4 clk_i = ~clk_i;

  fdds_core i_fdds_core
  (
    .clk_i            (clk_i),
    .rst_i            (rst_i),
    .ce_i             (1'b1),
    .wb_cyc_i         (wb_cyc),
    .wb_stb_i         (wb_stb),
    .wb_we_i          (wb_we),
    .wb_adr_i         (wb_adr),
    .wb_sel_i         (4'hF),
    .wb_dat_i         (wb_wdat),
    .wb_dat_o         (wb_rdat),
    .wb_ack_o         (wb_ack),
    .io_update_i      (upd_pin),
    .profile_inputs_i (prof),
    .sync_clk_o       (sync_clk),
    .cs_n_i           (cs_n),
    .sclk_i           (sclk),
    .sdio0_i          (sdio0),
    .sdio0_o          (sdo),
    .sdio0_oe_o       (sdo_oe),
    .sdio1_i          (sdio1),
    .sdio2_i          (1'b0),
    .sdio3_i          (sdio3),
    .dac_o            (dac_o)
  );

  fdds_host i_fdds_host
  (
    .clk_i    (clk_i),
    .cs_n_o   (cs_n),
    .sclk_o   (sclk),
    .sdo_o    (host_sdo),
    .sdi_i    (sdio0),
    .update_o (upd_pin)
  );

  // --------
  // Tasks
  // --------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks=%0d errors=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_wdat <= d;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (wb_ack !== 1'b1 && k < 50);
    check(32'(wb_ack), 32'h1);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic spi(input logic [7:0] ins, input logic [31:0] d, input int nb,
                     input logic sel);
    i_fdds_host.xfer(ins, d, nb, sel, q);
  endtask

  task automatic upd();
    upd_cnt++;
    i_fdds_host.pulse_update();
  endtask

  function automatic logic [9:0] lane(input int i);
    return dac_o[10 * i +: 10];
  endfunction

  always @(posedge clk_i)
  begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 40000)
    begin
      error_cnt++;
      print_verdict();
    end
  end

  // --------
  // Sequence
  // --------
  initial
  begin
    repeat (16) @(posedge clk_i);
    check(32'(dac_o == {4{10'h200}}), 32'h1);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    foreach (ra[i])
    begin
      wb(1'b0, ra[i], 32'h0000_0000);
      check(q, rv[i]);
    end
    v0 = lane(0);
    spi(8'h05, 32'h0000_1000, 2, 1'b1);
    for (int i = 0; i < 4; i++)
      check(32'(lane(i)), 32'(v0));
    fork
      upd();
      repeat (40)
      begin
        @(posedge clk_i);
        check(32'((lane(1) ^ lane(0)) | (lane(2) ^ lane(0)) | (lane(3) ^ lane(0))), 32'h0);
      end
    join
    check(32'(lane(0) != v0), 32'h1);
    wb(1'b0, 8'h18, 32'h0000_0000);
    check(32'(q[7:0]), upd_cnt);
    spi(8'h00, 32'h0000_0020, 1, 1'b1);
    wb(1'b0, 8'h00, 32'h0000_0000);
    check(q, 32'h0000_0020);
    spi(8'h05, 32'h0000_2000, 2, 1'b1);
    upd();
    check(32'(lane(0) == lane(2) && lane(0) == lane(3)), 32'h1);
    check(32'(lane(1) != lane(0)), 32'h1);
    spi(8'h80, 32'h0000_0000, 1, 1'b1);
    check(q, 32'h0000_0020);
    wb(1'b1, 8'h00, 32'h0000_00F0);
    spi(8'h00, 32'h0000_0010, 1, 1'b0);
    wb(1'b0, 8'h00, 32'h0000_0000);
    check(q, 32'h0000_00F0);
    sdio3 <= 1'b1;
    spi(8'h00, 32'h0000_0010, 1, 1'b1);
    sdio3 <= 1'b0;
    wb(1'b0, 8'h00, 32'h0000_0000);
    check(q, 32'h0000_00F0);
    spi(8'h04, 32'h4000_0000, 4, 1'b1);
    upd();
    foreach (s[i])
    begin
      @(posedge clk_i);
      s[i] = lane(0);
    end
    check(32'(s[4]), 32'(s[0]));
    check(32'(s[1] != s[0]), 32'h1);
    wb(1'b0, 8'h18, 32'h0000_0000);
    check(32'(q[7:0]), upd_cnt);
    for (int p = 8; p >= 0; p -= 8)
    begin
      n = 0;
      repeat (16)
      begin
        @(posedge clk_i);
        n += int'(sync_clk === 1'b1);
      end
      check(n, p);
      wb(1'b1, 8'h04, 32'h0000_0020);
      upd();
    end
    // Half-turn keying on ch0/ch2, ramp lanes: ch0/1 held full, ch2/3 ramp down
    prof <= 4'h5;
    sdio1 <= 1'b1;
    wb(1'b1, 8'h04, 32'h0000_2010);
    upd();
    repeat (80) @(posedge clk_i);
    wb(1'b0, 8'h18, 32'h0000_0000);
    check(32'(q[11:8]), 32'h5);
    check(32'(lane(2)) + 32'(lane(3)), 32'h400);
    n = lane(0) + lane(3);
    @(posedge clk_i);
    n += lane(0) + lane(3);
    check(32'(n != 32'h800), 32'h1);
    print_verdict();
  end
endmodule

bind fdds_core fdds_core_sva i_fdds_core_sva
(
  .clk_i,
  .rst_i,
  .wb_cyc_i,
  .wb_stb_i,
  .wb_ack_o,
  .sync_clk_o,
  .cs_n_i,
  .sclk_i,
  .sdio0_o,
  .sdio0_oe_o,
  .dac_o
);
`default_nettype wire
